// ==== tb/rtmsd_ctrl_chk.sv ====
`timescale 1ns/1ps
`default_nettype none
module rtmsd_ctrl_chk
  import rtmsd_pkg::*;
#(
  parameter int CONFIRMS  = FIELD_CONFIRMS,
  parameter int CHECK_CYC = FIELD_CHECK_CYC
) (
  input wire logic       mclk,
  input wire logic       nrst,
  input wire logic       fieldDetect,
  input wire logic       talksFirst,
  input wire logic       battery_assisted,
  input wire logic       serial_param_set_command,
  input wire logic [5:0] muteCount,
  input wire logic [3:0] muteTimeout,
  input wire logic       mute_timeout_enable,
  input wire logic       pinUnmuteSelect,
  input wire logic [3:0] idleTimeout,
  input wire logic       idle_timeout_enable,
  input wire logic [3:0] sleepTimeout,
  input wire logic       msgDone,
  input wire logic       transmitting,
  input wire logic       muted,
  input wire logic       sleeping,
  input wire logic       startBoot,
  input wire logic       cmdAccept,
  input wire logic       encourageOn
);
  localparam int MINRUN = (CONFIRMS - 1) * CHECK_CYC;
  int   fieldRun;
  logic encCond;
  assign encCond = battery_assisted && !serial_param_set_command && (sleepTimeout != 4'h0)
                   && (talksFirst ? (idle_timeout_enable && (muteCount != 6'h00)
                   && (muteTimeout != 4'h0)) : (idleTimeout != 4'h0));
  // consecutive cycles of field present
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) fieldRun <= 0;
    else fieldRun <= fieldDetect ? fieldRun + 1 : 0;
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);
  chk_xmit_no_accept: assert property (transmitting |-> !cmdAccept)
    else $error("command accepted while sending");
  chk_sleep_no_accept: assert property (sleeping |-> !cmdAccept)
    else $error("command accepted while asleep");
  chk_mute_silent: assert property (muted |-> !transmitting)
    else $error("sending while muted");
  chk_boot_confirm: assert property (startBoot |-> fieldRun >= MINRUN)
    else $error("wake without four field checks");
  chk_xmit_holds: assert property (transmitting && !msgDone && fieldDetect |=> transmitting)
    else $error("sending stopped before message end");
  chk_mute_holds: assert property (muted && fieldDetect && !mute_timeout_enable
    && !encourageOn && !pinUnmuteSelect |=> muted)
    else $error("mute ended without cause");
  chk_field_unmute: assert property (muted && !fieldDetect |-> ##[1:4] !muted)
    else $error("mute kept after field loss");
  chk_enc_on: assert property (encCond [*2] |-> encourageOn)
    else $error("sleep encouragement missing");
  chk_enc_off: assert property ((!encCond) [*2] |-> !encourageOn)
    else $error("sleep encouragement without conditions");
  cov_wake: cover property (startBoot);
  cov_unmute: cover property ($fell(muted) && fieldDetect);
  cov_enc: cover property (encourageOn);
endmodule : rtmsd_ctrl_chk
bind rtmsd_ctrl rtmsd_ctrl_chk #(.CONFIRMS(CONFIRMS), .CHECK_CYC(CHECK_CYC)) u_chk (
  .mclk, .nrst, .fieldDetect, .talksFirst, .battery_assisted, .serial_param_set_command,
  .muteCount, .muteTimeout, .mute_timeout_enable, .pinUnmuteSelect, .idleTimeout,
  .idle_timeout_enable, .sleepTimeout, .msgDone, .transmitting, .muted, .sleeping,
  .startBoot, .cmdAccept, .encourageOn);
`default_nettype wire

// ==== tb/rtmsd_reader.sv ====
`timescale 1ns/1ps
`default_nettype none
module rtmsd_reader (
  input  wire logic mclk,
  input  wire logic fieldOn,
  input  wire logic cmdReq,
  output var  logic fieldDetect,
  output var  logic readerCmd
);
  // commands only reach the tag while the field is up
  always_ff @(posedge mclk) begin
    fieldDetect <= fieldOn;
    readerCmd   <= cmdReq && fieldOn;
  end
endmodule : rtmsd_reader
`default_nettype wire

// ==== tb/testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam int ACT = 0, BOOT = 1, SLP = 2, MUTE = 3, XMIT = 4;
  logic       mclk, nrst, fieldOn, cmdReq, fieldDetect, readerCmd, talksFirst;
  logic       battery_assisted, serial_param_set_command, mute_timeout_enable;
  logic       pinUnmuteSelect, aux_edge_input, idle_timeout_enable, bootDone, msgDone;
  logic [5:0] muteCount;
  logic [3:0] muteTimeout, holdOff, idleTimeout, initCmdTimeout, sleepTimeout;
  logic [1:0] timeoutUnits, holdOffUnits;
  logic       active, sleeping, startBoot, transmitting, muted, cmdAccept, encourageOn;
  int         err_count, total_checks, n;
  rtmsd_reader RDR (.mclk, .fieldOn, .cmdReq, .fieldDetect, .readerCmd);
  rtmsd_ctrl #(.CONFIRMS(4), .CHECK_CYC(5), .TICK_DIV(2)) DUT (.mclk, .nrst, .fieldDetect,
    .talksFirst, .battery_assisted, .serial_param_set_command, .muteCount, .muteTimeout,
    .timeoutUnits, .mute_timeout_enable, .pinUnmuteSelect, .aux_edge_input, .holdOff,
    .holdOffUnits, .idleTimeout, .idle_timeout_enable, .initCmdTimeout, .sleepTimeout,
    .bootDone, .msgDone, .readerCmd, .active, .sleeping, .startBoot, .transmitting, .muted,
    .cmdAccept, .encourageOn);
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  task automatic step(input int m);
    repeat (m) @(posedge mclk);
    #1;
  endtask : step
  task automatic final_report();
    if (err_count == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : final_report
  task automatic cmp(input string what, input logic got, input logic exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %s exp %b got %b", what, exp, got);
    end
  endtask : cmp
  function automatic logic pick(input int k);
    logic [4:0] v;
    v = {transmitting, muted, sleeping, startBoot, active};
    return v[k];
  endfunction : pick
  // bounded wait on one output, c returns the cycles spent
  task automatic await(input int k, input logic v, input int lim, output int c);
    for (c = 0; pick(k) !== v; c++) begin
      if (c == lim) begin
        err_count++;
        $display("BAD wait%0d exp %b got %b", k, v, pick(k));
        final_report();
      end
      step(1);
    end
  endtask : await
  task automatic wake();
    fieldOn = 1'b1;
    await(BOOT, 1'b1, 300, n);
    bootDone = 1'b1;
    step(1);
    bootDone = 1'b0;
  endtask : wake
  task automatic send_msg();
    await(XMIT, 1'b1, 80, n);
    cmp("cmdAccept", cmdAccept, 1'b0);
    msgDone = 1'b1;
    step(1);
    msgDone = 1'b0;
  endtask : send_msg
  task automatic t_mute_count();
    talksFirst = 1'b1;
    step(50);
    cmp("active", active, 1'b0);
    wake();
    send_msg();
    cmp("muted", muted, 1'b0);
    send_msg();
    await(MUTE, 1'b1, 20, n);
    step(150);
    cmp("muted", muted, 1'b1);
  endtask : t_mute_count
  task automatic t_aux_timeout();
    mute_timeout_enable = 1'b1;
    muteTimeout = 4'h2;
    timeoutUnits = 2'h1;
    pinUnmuteSelect = 1'b1;
    aux_edge_input = 1'b1;
    await(MUTE, 1'b0, 20, n);
    pinUnmuteSelect = 1'b0;
    aux_edge_input = 1'b0;
    send_msg();
    send_msg();
    await(MUTE, 1'b1, 20, n);
    await(MUTE, 1'b0, 200, n);
    cmp("muteLen", n inside {[34:46]}, 1'b1);
    await(XMIT, 1'b1, 80, n);
  endtask : t_aux_timeout
  task automatic t_field_loss();
    mute_timeout_enable = 1'b0;
    send_msg();
    send_msg();
    await(MUTE, 1'b1, 20, n);
    fieldOn = 1'b0;
    await(MUTE, 1'b0, 10, n);
    await(SLP, 1'b1, 300, n);
    cmp("cmdAccept", cmdAccept, 1'b0);
  endtask : t_field_loss
  task automatic t_rtf_idle();
    talksFirst = 1'b0;
    idle_timeout_enable = 1'b1;
    idleTimeout = 4'h4;
    timeoutUnits = 2'h0;
    wake();
    await(ACT, 1'b1, 20, n);
    cmp("cmdAccept", cmdAccept, 1'b1);
    cmdReq = 1'b1;
    step(1);
    cmdReq = 1'b0;
    await(SLP, 1'b1, 80, n);
    cmp("cmdAccept", cmdAccept, 1'b0);
    idle_timeout_enable = 1'b0;
    wake();
    step(200);
    cmp("active", active, 1'b1);
  endtask : t_rtf_idle
  task automatic t_encourage();
    battery_assisted = 1'b1;
    sleepTimeout = 4'h1;
    step(3);
    cmp("encourageOn", encourageOn, 1'b1);
    serial_param_set_command = 1'b1;
    step(3);
    cmp("encourageOn", encourageOn, 1'b0);
    serial_param_set_command = 1'b0;
    talksFirst = 1'b1;
    idle_timeout_enable = 1'b1;
    muteTimeout = 4'h2;
    step(3);
    cmp("encourageOn", encourageOn, 1'b1);
    muteTimeout = 4'h0;
    step(3);
    cmp("encourageOn", encourageOn, 1'b0);
  endtask : t_encourage
  initial begin
    {nrst, fieldOn, cmdReq, talksFirst, battery_assisted, serial_param_set_command} = '0;
    {mute_timeout_enable, pinUnmuteSelect, aux_edge_input, idle_timeout_enable} = '0;
    {bootDone, msgDone, muteTimeout, idleTimeout, initCmdTimeout, sleepTimeout} = '0;
    {timeoutUnits, holdOffUnits} = '0;
    muteCount = 6'h02;
    holdOff = 4'h1;
    err_count = 0;
    total_checks = 0;
    step(10);
    nrst = 1'b1;
    cmp("sleeping", sleeping, 1'b1);
    t_mute_count();
    t_aux_timeout();
    t_field_loss();
    t_rtf_idle();
    t_encourage();
    final_report();
  end
endmodule : testbench
`default_nettype wire

// ==== verilog/rtmsd_ctrl.sv ====
`timescale 1ns/1ps
`default_nettype none
// Contract
// [R1] tag-talks-first: keep sending tag messages while field present and not muted
// [R2] mute after programmed 6-bit count of tag messages sent
// [R3] by default mute ends only when field is lost
// [R4] pin-edge option: rising aux input edge ends mute, restarts sending
// [R5] mute ends after 4-bit count times 2-bit unit step
// [R6] mute timeout acts only with its enable set
// [R7] interval between tag messages set by maximum hold-off value
// [R8] between messages sit listening for mute or reader command
// [R9] battery tag repeats send, self-mute, unmute cycle until field loss
// [R10] battery tag accepts reader commands except while transmitting
// [R11] talks-first sleep encouragement needs all six listed conditions
// [R12] talks-first encouragement forces mute timeout enable
// [R13] talks-first encouraged active time is about twice mute plus timeout time
// [R14] reader-talks-first: stay active idle in ready while field present
// [R15] leave active after 4-bit idle count times 2-bit unit step
// [R16] idle timeout acts only with its enable; no replies while off
// [R17] forced idle duty cycle alone gives about 93 percent active
// [R18] reader-talks-first encouragement needs battery, sleep, idle nonzero, no serial set
// [R19] reader-talks-first encouragement forces idle timeout enable
// [R20] return to sleep if no command within initial-command timeout after boot; code applies it only under reader-talks-first encouragement
// [R21] encouraged with nonzero initial timeout: active about six times it
// [R22] encouraged with zero initial timeout: active about twice idle timeout
// [R23] wake only after four positive field checks 25 us apart
// [R24] each timeout is count times step chosen by its unit field
module rtmsd_ctrl
  import rtmsd_pkg::*;
#(
  parameter int CONFIRMS  = FIELD_CONFIRMS,
  parameter int CHECK_CYC = FIELD_CHECK_CYC,
  parameter int TICK_DIV  = TICK_CYCLES
) (
  input  wire logic       mclk,
  input  wire logic       nrst,
  input  wire logic       fieldDetect,
  input  wire logic       talksFirst,
  input  wire logic       battery_assisted,
  input  wire logic       serial_param_set_command,
  input  wire logic [5:0] muteCount,
  input  wire logic [3:0] muteTimeout,
  input  wire logic [1:0] timeoutUnits,
  input  wire logic       mute_timeout_enable,
  input  wire logic       pinUnmuteSelect,
  input  wire logic       aux_edge_input,
  input  wire logic [3:0] holdOff,
  input  wire logic [1:0] holdOffUnits,
  input  wire logic [3:0] idleTimeout,
  input  wire logic       idle_timeout_enable,
  input  wire logic [3:0] initCmdTimeout,
  input  wire logic [3:0] sleepTimeout,
  input  wire logic       bootDone,
  input  wire logic       msgDone,
  input  wire logic       readerCmd,
  output var  logic       active,
  output var  logic       sleeping,
  output var  logic       startBoot,
  output var  logic       transmitting,
  output var  logic       muted,
  output logic            cmdAccept,
  output var  logic       encourageOn
);

  rtmsd_state_t state;
  rtmsd_state_t next_state;

  // check spacing counter sized from the spacing parameter
  localparam int CHK_W = $clog2(CHECK_CYC + 1);

  logic             tick;
  logic [5:0]       sentCnt;
  logic [CHK_W-1:0] checkCnt;
  logic [2:0] confirmCnt;
  logic       auxPrev;
  logic       gotCmd;
  logic       sleepHold;

  wire logic ttfEncourage = battery_assisted && idle_timeout_enable && (sleepTimeout != 4'h0)
                          && (muteCount != 6'h00) && (muteTimeout != 4'h0)
                          && !serial_param_set_command; // [R11]
  wire logic rtfEncourage = battery_assisted && (sleepTimeout != 4'h0)
                          && (idleTimeout != 4'h0) && !serial_param_set_command; // [R18]
  wire logic encourage    = talksFirst ? ttfEncourage : rtfEncourage;
  wire logic muteToEn     = mute_timeout_enable || ttfEncourage; // [R12]
  wire logic idleToEn     = idle_timeout_enable || rtfEncourage; // [R19]
  wire logic auxRise      = aux_edge_input && !auxPrev;

  wire logic [TIME_W-1:0] muteLen = rtmsd_duration(muteTimeout, timeoutUnits); // [R5] [R24]
  wire logic [TIME_W-1:0] idleLen = rtmsd_duration(idleTimeout, timeoutUnits); // [R15] [R24]
  wire logic [TIME_W-1:0] holdLen = rtmsd_duration(holdOff, holdOffUnits); // [R7]
  wire logic [TIME_W-1:0] initLen = rtmsd_duration(initCmdTimeout, timeoutUnits);
  wire logic [TIME_W-1:0] sleepLen = rtmsd_duration(sleepTimeout, timeoutUnits);

  // one active window holds two idle timeouts / six initial-command windows
  wire logic [TIME_W-1:0] encIdleLen = (initCmdTimeout != 4'h0)
                                     ? TIME_W'(initLen * 24'h000006)
                                     : TIME_W'(idleLen * 24'h000002); // [R21] [R22]

  wire logic enterActive = (state == RTMSD_BOOT) && bootDone;
  wire logic checkDue    = (checkCnt == CHK_W'(CHECK_CYC - 1));
  wire logic sentLast    = (muteCount != 6'h00) && (sentCnt == muteCount - 6'h01);
  // initial detection plus three confirmations
  wire logic lastCheck   = checkDue && (confirmCnt == 3'(CONFIRMS - 2)); // [R23]
  wire logic checkFail   = checkDue && !fieldDetect; // [R23]
  wire logic pinUnmute   = pinUnmuteSelect && auxRise; // [R4]

  logic holdExp;
  logic muteExp;
  logic idleExp;
  logic initExp;
  logic sleepExp;
  logic activeExp;

  // timer controls
  wire logic holdStart  = (state == RTMSD_XMIT);
  wire logic holdRun    = (state == RTMSD_LISTEN);
  wire logic muteStart  = (state != RTMSD_MUTED);
  wire logic idleStart  = enterActive || readerCmd;
  wire logic idleRun    = idleToEn && (state == RTMSD_READY); // [R16]
  wire logic initRun    = rtfEncourage && (initCmdTimeout != 4'h0) && !gotCmd; // [R20]
  wire logic actRun     = ttfEncourage && talksFirst && active;
  wire logic sleepStart = (state != RTMSD_SLEEP);
  wire logic [TIME_W-1:0] idleSel = encourage ? encIdleLen : idleLen;
  wire logic [TIME_W-1:0] actLen  = TIME_W'((muteLen + TIME_W'(muteCount) * holdLen)
                                            * 24'h000002); // [R13]

  // state-class decode for the registered outputs and the sleep hold
  wire logic enterSleep = (state != RTMSD_SLEEP) && (next_state == RTMSD_SLEEP);
  wire logic nextAsleep = (next_state == RTMSD_SLEEP) || (next_state == RTMSD_CONFIRM);
  wire logic nextAwake  = !nextAsleep && (next_state != RTMSD_BOOT || state == RTMSD_BOOT);
  wire logic bootStart  = (state == RTMSD_CONFIRM) && (next_state == RTMSD_BOOT);

  rtmsd_tick #(
    .DIV (TICK_DIV)
  ) u_tick (
    .mclk (mclk),
    .nrst (nrst),
    .tick (tick)
  );

  rtmsd_timer u_hold (
    .mclk    (mclk),
    .nrst    (nrst),
    .tick    (tick),
    .start   (holdStart),
    .run     (holdRun),
    .length  (holdLen),
    .expired (holdExp)
  );

  rtmsd_timer u_mute (
    .mclk    (mclk),
    .nrst    (nrst),
    .tick    (tick),
    .start   (muteStart),
    .run     (muteToEn), // [R6]
    .length  (muteLen),
    .expired (muteExp)
  );

  rtmsd_timer u_idle (
    .mclk    (mclk),
    .nrst    (nrst),
    .tick    (tick),
    .start   (idleStart),
    .run     (idleRun), // [R16]
    .length  (idleSel),
    .expired (idleExp)
  );

  rtmsd_timer u_init (
    .mclk    (mclk),
    .nrst    (nrst),
    .tick    (tick),
    .start   (enterActive),
    .run     (initRun),
    .length  (initLen),
    .expired (initExp)
  );

  // active-window budget for talks-first encouragement
  rtmsd_timer u_active (
    .mclk    (mclk),
    .nrst    (nrst),
    .tick    (tick),
    .start   (enterActive),
    .run     (actRun),
    .length  (actLen), // [R13]
    .expired (activeExp)
  );

  rtmsd_timer u_sleep (
    .mclk    (mclk),
    .nrst    (nrst),
    .tick    (tick),
    .start   (sleepStart),
    .run     (encourage),
    .length  (sleepLen),
    .expired (sleepExp)
  );

  always_comb begin
    next_state = state;
    unique case (state)
      RTMSD_SLEEP: begin
        if (fieldDetect && !sleepHold) begin
          next_state = RTMSD_CONFIRM;
        end
      end
      RTMSD_CONFIRM: begin
        if (checkFail) begin
          next_state = RTMSD_SLEEP; // [R23]
        end else if (lastCheck) begin
          next_state = RTMSD_BOOT; // [R23]
        end
      end
      RTMSD_BOOT: begin
        if (!fieldDetect) begin
          next_state = RTMSD_SLEEP;
        end else if (bootDone) begin
          next_state = talksFirst ? RTMSD_XMIT : RTMSD_READY; // [R1] [R14]
        end
      end
      RTMSD_XMIT: begin
        if (msgDone) begin
          next_state = sentLast ? RTMSD_MUTED : RTMSD_LISTEN; // [R2]
        end
      end
      RTMSD_LISTEN: begin
        if (!fieldDetect || activeExp) begin
          next_state = RTMSD_SLEEP;
        end else if (holdExp) begin
          next_state = RTMSD_XMIT; // [R1] [R8]
        end
      end
      RTMSD_MUTED: begin
        if (!fieldDetect || activeExp) begin
          next_state = RTMSD_SLEEP; // [R3] [R9]
        end else if (pinUnmute || muteExp) begin
          next_state = RTMSD_XMIT; // [R4] [R5] [R9]
        end
      end
      RTMSD_READY: begin
        if (!fieldDetect || idleExp || initExp) begin
          next_state = RTMSD_SLEEP; // [R15] [R17] [R20]
        end
      end
      default: next_state = RTMSD_SLEEP;
    endcase
  end

  assign cmdAccept = (state == RTMSD_LISTEN) || (state == RTMSD_MUTED)
                   || (state == RTMSD_READY); // [R10] [R16]

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      state <= RTMSD_SLEEP;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      checkCnt   <= '0;
      confirmCnt <= '0;
    end else if (state != RTMSD_CONFIRM) begin
      checkCnt   <= '0;
      confirmCnt <= '0;
    end else if (checkDue) begin
      checkCnt   <= '0;
      confirmCnt <= confirmCnt + 3'h1;
    end else begin
      checkCnt   <= checkCnt + 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      sentCnt <= '0;
    end else if (state == RTMSD_MUTED || !active) begin
      sentCnt <= '0;
    end else if (state == RTMSD_XMIT && msgDone) begin
      sentCnt <= sentCnt + 6'h01; // [R2]
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      auxPrev <= 1'b0;
      gotCmd  <= 1'b0;
    end else begin
      auxPrev <= aux_edge_input;
      gotCmd  <= enterActive ? 1'b0 : (gotCmd || (readerCmd && cmdAccept));
    end
  end

  // encouraged sleep is kept until the sleep timer runs out or encouragement drops
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      sleepHold <= 1'b0;
    end else if (enterSleep && encourage) begin
      sleepHold <= 1'b1;
    end else if (sleepExp || !encourage) begin
      sleepHold <= 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      active    <= 1'b0;
      sleeping  <= 1'b1;
      startBoot <= 1'b0;
    end else begin
      active    <= nextAwake;
      sleeping  <= nextAsleep;
      startBoot <= bootStart;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      transmitting <= 1'b0;
      muted        <= 1'b0;
    end else begin
      transmitting <= (next_state == RTMSD_XMIT);
      muted        <= (next_state == RTMSD_MUTED);
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      encourageOn <= 1'b0;
    end else begin
      encourageOn <= encourage;
    end
  end

endmodule : rtmsd_ctrl
`default_nettype wire

// ==== verilog/rtmsd_pkg.sv ====
package rtmsd_pkg;

  localparam int CLK_HZ          = 100_000_000;
  localparam int TICK_NS         = 1000;
  localparam int CLK_NS          = 1_000_000_000 / CLK_HZ;
  localparam int TICK_CYCLES     = (TICK_NS + CLK_NS - 1) / CLK_NS;
  localparam int FIELD_CHECK_US  = 25;
  localparam int FIELD_CHECK_CYC = (FIELD_CHECK_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int FIELD_CONFIRMS  = 4;
  localparam int TICK_CNT_W      = 16;
  localparam int TIME_W          = 24;

  // step per unit encoding, in slow ticks
  localparam logic [TIME_W-1:0] UNIT_STEP0 = 24'h000001;
  localparam logic [TIME_W-1:0] UNIT_STEP1 = 24'h00000a;
  localparam logic [TIME_W-1:0] UNIT_STEP2 = 24'h000064;
  localparam logic [TIME_W-1:0] UNIT_STEP3 = 24'h0003e8;

  typedef enum logic [2:0] {
    RTMSD_SLEEP   = 3'b000,
    RTMSD_CONFIRM = 3'b001,
    RTMSD_BOOT    = 3'b010,
    RTMSD_XMIT    = 3'b011,
    RTMSD_LISTEN  = 3'b100,
    RTMSD_MUTED   = 3'b101,
    RTMSD_READY   = 3'b110
  } rtmsd_state_t;

  function automatic logic [TIME_W-1:0] rtmsd_duration(input logic [3:0] cnt,
                                                        input logic [1:0] unit);
    logic [TIME_W-1:0] step;
    step = UNIT_STEP0;
    unique case (unit)
      2'h0: step = UNIT_STEP0;
      2'h1: step = UNIT_STEP1;
      2'h2: step = UNIT_STEP2;
      2'h3: step = UNIT_STEP3;
    endcase
    rtmsd_duration = TIME_W'(step * {20'h00000, cnt});
  endfunction : rtmsd_duration

endpackage : rtmsd_pkg

// ==== verilog/rtmsd_tick.sv ====
`timescale 1ns/1ps
`default_nettype none
module rtmsd_tick
  import rtmsd_pkg::*;
#(
  parameter int DIV = TICK_CYCLES
) (
  input  wire logic mclk,
  input  wire logic nrst,
  output var  logic tick
);
  logic [TICK_CNT_W-1:0] cnt;
  wire wrap = (cnt == TICK_CNT_W'(DIV - 1));

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      cnt  <= '0;
      tick <= 1'b0;
    end else begin
      cnt  <= wrap ? '0 : cnt + 1'b1;
      tick <= wrap;
    end
  end
endmodule : rtmsd_tick
`default_nettype wire

// ==== verilog/rtmsd_timer.sv ====
`timescale 1ns/1ps
`default_nettype none
module rtmsd_timer
  import rtmsd_pkg::*;
(
  input  wire logic              mclk,
  input  wire logic              nrst,
  input  wire logic              tick,
  input  wire logic              start,
  input  wire logic              run,
  input  wire logic [TIME_W-1:0] length,
  output var  logic              expired
);
  logic [TIME_W-1:0] remain;
  wire               atZero = (remain == '0);

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      remain  <= '0;
      expired <= 1'b0;
    end else if (start) begin
      remain  <= length;
      expired <= 1'b0;
    end else if (!run) begin
      expired <= 1'b0;
    end else if (tick) begin
      remain  <= atZero ? remain : remain - 1'b1;
      expired <= atZero;
    end else begin
      expired <= 1'b0;
    end
  end
endmodule : rtmsd_timer
`default_nettype wire
